/* File: hdl/pmb_pkg.sv */
// package: offsets, field positions, reset values and timing counts of the disable bank
package pmb_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NVM_WAKE_NS = 1000;
  localparam int unsigned NVM_WAKE_CYC = NVM_WAKE_NS / CLK_PERIOD_NS;
  localparam int unsigned CLK_PER_INSTR = 4;
  localparam int unsigned SFR_QUIET_INSTR = 2;
  localparam int unsigned SFR_QUIET_CYC = SFR_QUIET_INSTR * CLK_PER_INSTR;
  localparam int unsigned CNT_W = 8;
  // bus geometry
  localparam int unsigned ADR_W = 16;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned IDX_W = 14;
  localparam int unsigned REG_W = 8;
  localparam int unsigned NUM_REGS = 6;
  localparam int unsigned NUM_SLOTS = NUM_REGS * REG_W;
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL_0 = 14'h0ee1;
  localparam logic [IDX_W-1:0] IDX_CTRL_1 = 14'h0ee2;
  localparam logic [IDX_W-1:0] IDX_CTRL_2 = 14'h0ee3;
  localparam logic [IDX_W-1:0] IDX_CTRL_3 = 14'h0ee4;
  localparam logic [IDX_W-1:0] IDX_CTRL_4 = 14'h0ee5;
  localparam logic [IDX_W-1:0] IDX_CTRL_5 = 14'h0ee6;
  localparam logic [IDX_W-1:0] IDX_STATUS = 14'h0ee7;
  // reset value and implemented bits, control 5 in the top byte
  localparam logic [REG_W-1:0] RESET_CTRL = 8'h00;
  localparam logic [NUM_SLOTS-1:0] IMPL_MASK = {8'h01, 8'hf1, 8'h0f, 8'h67, 8'h7f, 8'hff};
  // flat field positions, register k bit b sits at k*8+b
  localparam int unsigned POS_SYS_CLOCK_NET = 7;
  localparam int unsigned POS_FIXED_VREF = 6;
  localparam int unsigned POS_VOLT_DETECT = 5;
  localparam int unsigned POS_CRC_ENGINE = 4;
  localparam int unsigned POS_MEM_SCANNER = 3;
  localparam int unsigned POS_NONVOLATILE = 2;
  localparam int unsigned POS_CLOCK_REF = 1;
  localparam int unsigned POS_PIN_CHANGE_IRQ = 0;
  localparam int unsigned POS_TIMER_0 = 8;
  localparam int unsigned POS_ZERO_CROSS = 16;
  localparam int unsigned POS_COMPARATOR_1 = 17;
  localparam int unsigned POS_ADC = 21;
  localparam int unsigned POS_DAC = 22;
  localparam int unsigned POS_CAPCOMP_1 = 24;
  localparam int unsigned POS_PULSE_MOD_3 = 26;
  localparam int unsigned POS_WAVEFORM_GEN_1 = 32;
  localparam int unsigned POS_SYNC_SERIAL_1 = 36;
  localparam int unsigned POS_ASYNC_SERIAL_1 = 38;
  localparam int unsigned POS_SIGNAL_MODULATOR = 40;
  // status register fields
  localparam int unsigned STAT_SETTLING = 0;
  localparam int unsigned STAT_NVM_READY = 1;
endpackage

/* File: hdl/pmb_reg_if.sv */
// interface: register access between the bus slave and the disable bank
`timescale 1ns/1ps
`default_nettype none
interface pmb_reg_if;
  logic wr_stb;
  logic [pmb_pkg::IDX_W-1:0] index;
  logic [pmb_pkg::REG_W-1:0] wdata;
  logic [pmb_pkg::REG_W-1:0] rdata;
  modport slave (output wr_stb, output index, output wdata, input rdata);
  modport bank (input wr_stb, input index, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: hdl/pmb_wb_slave.sv */
// module: classic wishbone slave with one wait state, byte wide registers in lane 0
`timescale 1ns/1ps
`default_nettype none
module pmb_wb_slave (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // wishbone
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [pmb_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [pmb_pkg::DAT_W-1:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic o_wb_ack,
  output logic [pmb_pkg::DAT_W-1:0] o_wb_dat,
  // register side
  pmb_reg_if.slave bus
);
  logic req;

  assign req = i_wb_cyc & i_wb_stb;
  assign bus.index = i_wb_adr[pmb_pkg::ADR_W-1:2];
  assign bus.wdata = i_wb_dat[pmb_pkg::REG_W-1:0];
  // write lands on the edge where the master samples ack
  assign bus.wr_stb = req & i_wb_we & i_wb_sel[0] & o_wb_ack;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= req & ~o_wb_ack;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wb_dat <= 32'h00000000;
    end else if (req && !o_wb_ack && !i_wb_we) begin
      o_wb_dat <= {24'h000000, bus.rdata};
    end
  end
endmodule
`default_nettype wire

/* File: hdl/pmb_settle.sv */
// module: per peripheral hold flop and quiet counter after re-enable
`timescale 1ns/1ps
`default_nettype none
module pmb_settle #(
  parameter int unsigned CYCLES = 1
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // control
  input wire logic i_off,
  output logic o_hold,
  output logic o_quiet
);
  logic [pmb_pkg::CNT_W-1:0] cnt;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hold <= 1'b0;
    end else begin
      o_hold <= i_off;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= '0;
      o_quiet <= 1'b0;
    end else if (i_off) begin
      cnt <= '0;
      o_quiet <= 1'b0;
    end else if (o_hold) begin
      cnt <= pmb_pkg::CNT_W'(CYCLES);
      o_quiet <= 1'b1;
    end else if (cnt > pmb_pkg::CNT_W'(1)) begin
      cnt <= cnt - pmb_pkg::CNT_W'(1);
      o_quiet <= 1'b1;
    end else begin
      cnt <= '0;
      o_quiet <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/pmb_bank.sv */
// module: peripheral disable register bank with wishbone access and sfr gating
// Contract
// - control 0 bit 7 set stops the undivided system clock network to peripherals.
// - peripherals on the divided-by-four clock keep their clock regardless.
// - control 0 bit 6 set disables the fixed voltage reference.
// - control 0 bit 5 set disables the voltage detector.
// - control 0 bit 4 set disables the crc engine.
// - control 0 bit 3 set disables the memory scanner.
// - scanner disable acts subject to the scanner configuration enable.
// - control 0 bit 2 set blocks memory access and control register writes.
// - control 0 bit 1 set disables the clock reference output.
// - control 0 bit 0 set disables pin change interrupts on all ports.
// - control 1 bits 0 to 6 each disable the timer of that number.
// - control 2 bit 6 disables the dac, bit 5 the adc.
// - control 2 bits 1 and 2 disable comparators 1 and 2.
// - control 2 bit 0 set disables the zero-cross detector.
// - zero-cross disable acts subject to the zero-cross configuration setting.
// - control 3 bits 3 and 2 disable pulse modulators 4 and 3.
// - control 3 bits 1 and 0 disable capture units 2 and 1.
// - control 4 bits 7 and 6 disable async serial ports 2 and 1.
// - control 4 bits 5 and 4 disable sync serial ports 2 and 1.
// - control 4 bit 0 disables waveform generator 1.
// - control 5 bit 0 disables the signal modulator.
// - a disabled peripheral is held in reset, writes ignored, reads zero.
// - clearing a disable bit releases the peripheral with reset register values.
// - every system reset clears all disable bits.
`timescale 1ns/1ps
`default_nettype none
module pmb_bank (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // wishbone
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [pmb_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [pmb_pkg::DAT_W-1:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic o_wb_ack,
  output logic [pmb_pkg::DAT_W-1:0] o_wb_dat,
  // configuration word straps
  input wire logic i_scanner_cfg_enable,
  input wire logic i_zero_cross_cfg,
  // peripheral register traffic, one slot per disable bit
  input wire logic [pmb_pkg::NUM_SLOTS-1:0] i_sfr_wr,
  input wire logic [pmb_pkg::NUM_SLOTS*pmb_pkg::REG_W-1:0] i_sfr_rdata,
  output logic [pmb_pkg::NUM_SLOTS-1:0] o_sfr_wr,
  output logic [pmb_pkg::NUM_SLOTS*pmb_pkg::REG_W-1:0] o_sfr_rdata,
  // clock network enables
  output logic o_fosc_clk_en,
  output logic o_fosc4_clk_en,
  // memory access enable
  output logic o_nvm_access_en,
  // peripheral reset holds
  output logic o_fixed_vref_hold,
  output logic o_volt_detect_hold,
  output logic o_crc_engine_hold,
  output logic o_mem_scanner_hold,
  output logic o_nonvolatile_hold,
  output logic o_clock_ref_hold,
  output logic o_pin_change_irq_hold,
  output logic [6:0] o_timer_hold,
  output logic o_zero_cross_hold,
  output logic [1:0] o_comparator_hold,
  output logic o_adc_hold,
  output logic o_dac_hold,
  output logic [1:0] o_capcomp_hold,
  output logic [1:0] o_pulse_mod_hold,
  output logic o_waveform_gen_1_hold,
  output logic [1:0] o_sync_serial_hold,
  output logic [1:0] o_async_serial_hold,
  output logic o_signal_modulator_hold,
  // quiet time after re-enable, per slot
  output logic [pmb_pkg::NUM_SLOTS-1:0] o_periph_settling
);
  pmb_reg_if reg_bus ();

  logic [pmb_pkg::NUM_SLOTS-1:0] ctrl;
  logic [pmb_pkg::NUM_SLOTS-1:0] eff;
  logic [pmb_pkg::NUM_SLOTS-1:0] hold;
  logic [pmb_pkg::NUM_SLOTS-1:0] quiet;
  logic scan_cfg_meta;
  logic scan_cfg;
  logic zcd_cfg_meta;
  logic zcd_cfg;
  logic any_settling;
  logic nvm_ready;
  logic [pmb_pkg::REG_W-1:0] status;

  pmb_wb_slave u_slave (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_wb_dat(i_wb_dat),
    .i_wb_sel(i_wb_sel),
    .o_wb_ack(o_wb_ack),
    .o_wb_dat(o_wb_dat),
    .bus(reg_bus.slave)
  );

  // configuration straps come from outside the clock domain
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // reset to enabled so the scanner is not held after reset
      scan_cfg_meta <= 1'b1;
      scan_cfg <= 1'b1;
    end else begin
      scan_cfg_meta <= i_scanner_cfg_enable;
      scan_cfg <= scan_cfg_meta;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      zcd_cfg_meta <= 1'b0;
      zcd_cfg <= 1'b0;
    end else begin
      zcd_cfg_meta <= i_zero_cross_cfg;
      zcd_cfg <= zcd_cfg_meta;
    end
  end

  // control registers, one byte each
  for (genvar k = 0; k < pmb_pkg::NUM_REGS; k++) begin : g_ctrl
    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        ctrl[k*pmb_pkg::REG_W +: pmb_pkg::REG_W] <= pmb_pkg::RESET_CTRL;
      end else if (reg_bus.wr_stb &&
                   reg_bus.index == pmb_pkg::IDX_W'(pmb_pkg::IDX_CTRL_0 + k)) begin
        ctrl[k*pmb_pkg::REG_W +: pmb_pkg::REG_W] <=
          reg_bus.wdata & pmb_pkg::IMPL_MASK[k*pmb_pkg::REG_W +: pmb_pkg::REG_W];
      end
    end
  end

  // effective disables after configuration word qualification
  always_comb begin
    eff = ctrl;
    // scanner not enabled by configuration is held off anyway
    eff[pmb_pkg::POS_MEM_SCANNER] = ctrl[pmb_pkg::POS_MEM_SCANNER] | ~scan_cfg;
    // configuration forcing zero-cross on overrides its disable bit
    eff[pmb_pkg::POS_ZERO_CROSS] = ctrl[pmb_pkg::POS_ZERO_CROSS] & ~zcd_cfg;
  end

  // per slot hold, quiet time and register gating
  for (genvar s = 0; s < pmb_pkg::NUM_SLOTS; s++) begin : g_slot
    if (pmb_pkg::IMPL_MASK[s]) begin : g_impl
      pmb_settle #(
        .CYCLES((s == pmb_pkg::POS_NONVOLATILE) ? pmb_pkg::NVM_WAKE_CYC :
                pmb_pkg::SFR_QUIET_CYC)
      ) u_settle (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_off(eff[s]),
        .o_hold(hold[s]),
        .o_quiet(quiet[s])
      );
    end else begin : g_none
      assign hold[s] = 1'b0;
      assign quiet[s] = 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        o_sfr_wr[s] <= 1'b0;
      end else begin
        o_sfr_wr[s] <= i_sfr_wr[s] & ~hold[s] & ~eff[s] & pmb_pkg::IMPL_MASK[s];
      end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        o_sfr_rdata[s*pmb_pkg::REG_W +: pmb_pkg::REG_W] <= 8'h00;
      end else if (hold[s] || !pmb_pkg::IMPL_MASK[s]) begin
        o_sfr_rdata[s*pmb_pkg::REG_W +: pmb_pkg::REG_W] <= 8'h00;
      end else begin
        o_sfr_rdata[s*pmb_pkg::REG_W +: pmb_pkg::REG_W] <=
          i_sfr_rdata[s*pmb_pkg::REG_W +: pmb_pkg::REG_W];
      end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        o_periph_settling[s] <= 1'b0;
      end else begin
        o_periph_settling[s] <= quiet[s];
      end
    end
  end

  // clock network enables
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_fosc_clk_en <= 1'b1;
      o_fosc4_clk_en <= 1'b1;
    end else begin
      o_fosc_clk_en <= ~eff[pmb_pkg::POS_SYS_CLOCK_NET];
      o_fosc4_clk_en <= 1'b1;
    end
  end

  // memory access waits out the wake time after re-enable
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_nvm_access_en <= 1'b1;
    end else begin
      o_nvm_access_en <= ~eff[pmb_pkg::POS_NONVOLATILE] &
                         ~hold[pmb_pkg::POS_NONVOLATILE] &
                         ~quiet[pmb_pkg::POS_NONVOLATILE];
    end
  end

  // named peripheral holds
  assign o_fixed_vref_hold = hold[pmb_pkg::POS_FIXED_VREF];
  assign o_volt_detect_hold = hold[pmb_pkg::POS_VOLT_DETECT];
  assign o_crc_engine_hold = hold[pmb_pkg::POS_CRC_ENGINE];
  assign o_mem_scanner_hold = hold[pmb_pkg::POS_MEM_SCANNER];
  assign o_nonvolatile_hold = hold[pmb_pkg::POS_NONVOLATILE];
  assign o_clock_ref_hold = hold[pmb_pkg::POS_CLOCK_REF];
  assign o_pin_change_irq_hold = hold[pmb_pkg::POS_PIN_CHANGE_IRQ];
  assign o_timer_hold = hold[pmb_pkg::POS_TIMER_0 +: 7];
  assign o_zero_cross_hold = hold[pmb_pkg::POS_ZERO_CROSS];
  assign o_comparator_hold = hold[pmb_pkg::POS_COMPARATOR_1 +: 2];
  assign o_adc_hold = hold[pmb_pkg::POS_ADC];
  assign o_dac_hold = hold[pmb_pkg::POS_DAC];
  assign o_capcomp_hold = hold[pmb_pkg::POS_CAPCOMP_1 +: 2];
  assign o_pulse_mod_hold = hold[pmb_pkg::POS_PULSE_MOD_3 +: 2];
  assign o_waveform_gen_1_hold = hold[pmb_pkg::POS_WAVEFORM_GEN_1];
  assign o_sync_serial_hold = hold[pmb_pkg::POS_SYNC_SERIAL_1 +: 2];
  assign o_async_serial_hold = hold[pmb_pkg::POS_ASYNC_SERIAL_1 +: 2];
  assign o_signal_modulator_hold = hold[pmb_pkg::POS_SIGNAL_MODULATOR];

  // status view
  assign any_settling = |quiet;
  assign nvm_ready = ~hold[pmb_pkg::POS_NONVOLATILE] & ~quiet[pmb_pkg::POS_NONVOLATILE];

  always_comb begin
    status = 8'h00;
    status[pmb_pkg::STAT_SETTLING] = any_settling;
    status[pmb_pkg::STAT_NVM_READY] = nvm_ready;
  end

  // read decode, unmapped reads return zero
  always_comb begin
    reg_bus.rdata = 8'h00;
    if (reg_bus.index == pmb_pkg::IDX_CTRL_0) begin
      reg_bus.rdata = ctrl[0 +: pmb_pkg::REG_W];
    end else if (reg_bus.index == pmb_pkg::IDX_CTRL_1) begin
      reg_bus.rdata = ctrl[8 +: pmb_pkg::REG_W];
    end else if (reg_bus.index == pmb_pkg::IDX_CTRL_2) begin
      reg_bus.rdata = ctrl[16 +: pmb_pkg::REG_W];
    end else if (reg_bus.index == pmb_pkg::IDX_CTRL_3) begin
      reg_bus.rdata = ctrl[24 +: pmb_pkg::REG_W];
    end else if (reg_bus.index == pmb_pkg::IDX_CTRL_4) begin
      reg_bus.rdata = ctrl[32 +: pmb_pkg::REG_W];
    end else if (reg_bus.index == pmb_pkg::IDX_CTRL_5) begin
      reg_bus.rdata = ctrl[40 +: pmb_pkg::REG_W];
    end else if (reg_bus.index == pmb_pkg::IDX_STATUS) begin
      reg_bus.rdata = status;
    end
  end
endmodule
`default_nettype wire

/* File: bench/pmb_bank_sva.sv */
// checker: bus timing and disable output relations of the bank
`timescale 1ns/1ps
`default_nettype none
module pmb_sva (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // bus
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [15:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic o_wb_ack,
  // straps and outputs
  input wire logic i_zero_cross_cfg,
  input wire logic o_fosc_clk_en,
  input wire logic o_fosc4_clk_en,
  input wire logic o_nvm_access_en,
  input wire logic o_nonvolatile_hold,
  input wire logic o_zero_cross_hold,
  input wire logic [6:0] o_timer_hold,
  input wire logic [47:0] o_sfr_wr,
  input wire logic [47:0] o_periph_settling
);
  logic [7:0] c0;
  logic [6:0] c1;
  wire wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack & i_wb_sel[0];
  // shadow of controls 0 and 1, taken at the acknowledged edge
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      c0 <= 8'h00;
      c1 <= 7'h00;
    end else if (wr && i_wb_adr[15:2] == pmb_pkg::IDX_CTRL_0) begin
      c0 <= i_wb_dat[7:0];
    end else if (wr && i_wb_adr[15:2] == pmb_pkg::IDX_CTRL_1) begin
      c1 <= i_wb_dat[6:0];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_nvm_shut; (!o_nvm_access_en) [*8]; endsequence
  sequence s_quiet; o_periph_settling[8] [*6]; endsequence
  property p_ack; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack; endproperty
  property p_div_clk; o_fosc4_clk_en; endproperty
  property p_sys_clk; o_fosc_clk_en == !$past(c0[7]); endproperty
  property p_nvm_hold;
    o_nonvolatile_hold == $past(c0[2]) && !(o_nonvolatile_hold && o_nvm_access_en);
  endproperty
  property p_nvm_wake;
    $fell(o_nonvolatile_hold) && $past(i_resetn) |->
      s_nvm_shut ##1 (!o_nvm_access_en) [*3] ##1 o_nvm_access_en;
  endproperty
  property p_timers; o_timer_hold == $past(c1); endproperty
  property p_gate; !o_sfr_wr[15] && !(o_nonvolatile_hold && o_sfr_wr[2]); endproperty
  property p_settle;
    $fell(o_timer_hold[0]) && $past(i_resetn) |->
      ##1 s_quiet ##1 o_periph_settling[8] [*2] ##1 !o_periph_settling[8];
  endproperty
  property p_zcd; i_zero_cross_cfg [*4] |-> !o_zero_cross_hold; endproperty
  property p_reset;
    $rose(i_resetn) |-> o_timer_hold == 7'h00 && o_fosc_clk_en && !o_nonvolatile_hold;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  a_div_clk: assert property (p_div_clk) else $error("divided clock stopped");
  a_sys_clk: assert property (p_sys_clk) else $error("clock enable wrong");
  a_nvm_hold: assert property (p_nvm_hold) else $error("memory hold wrong");
  a_nvm_wake: assert property (p_nvm_wake) else $error("memory wake time wrong");
  a_timers: assert property (p_timers) else $error("timer holds wrong");
  a_gate: assert property (p_gate) else $error("write passed while off");
  a_settle: assert property (p_settle) else $error("quiet time wrong");
  a_zcd: assert property (p_zcd) else $error("zero cross held despite strap");
  a_reset: assert property (p_reset) else $error("outputs wrong after reset");
endmodule
bind pmb_bank pmb_sva i_sva (.i_clk, .i_resetn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
  .i_wb_dat, .i_wb_sel, .o_wb_ack, .i_zero_cross_cfg, .o_fosc_clk_en, .o_fosc4_clk_en,
  .o_nvm_access_en, .o_nonvolatile_hold, .o_zero_cross_hold, .o_timer_hold, .o_sfr_wr,
  .o_periph_settling);
`default_nettype wire

/* File: bench/tb_top.sv */
// testbench: bus traffic, output checks and verdict for the disable bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic i_clk = 1'h0, i_resetn = 1'h0, i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
  logic [15:0] i_wb_adr = 16'h0000;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, mon_exp;
  logic [3:0] i_wb_sel = 4'h0;
  logic i_scanner_cfg_enable = 1'h1, i_zero_cross_cfg = 1'h0;
  logic [47:0] i_sfr_wr = '1, o_sfr_wr, o_periph_settling, regs = '0;
  logic [383:0] i_sfr_rdata = '0, o_sfr_rdata;
  logic o_wb_ack, o_fosc_clk_en, o_fosc4_clk_en, o_nvm_access_en, o_fixed_vref_hold;
  logic o_volt_detect_hold, o_crc_engine_hold, o_mem_scanner_hold, o_nonvolatile_hold;
  logic o_clock_ref_hold, o_pin_change_irq_hold, o_zero_cross_hold, o_adc_hold, o_dac_hold;
  logic o_waveform_gen_1_hold, o_signal_modulator_hold;
  logic [6:0] o_timer_hold;
  logic [1:0] o_comparator_hold, o_capcomp_hold, o_pulse_mod_hold;
  logic [1:0] o_sync_serial_hold, o_async_serial_hold;
  logic [29:0] got_h, exp_h;
  logic [7:0] exp_b;
  logic [383:0] rnd;
  logic [31:0] expq[$];
  int mismatches = 0, samples_checked = 0, cycles = 0;
  pmb_bank i_dut (.i_clk, .i_resetn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat,
    .i_wb_sel, .o_wb_ack, .o_wb_dat, .i_scanner_cfg_enable, .i_zero_cross_cfg, .i_sfr_wr,
    .i_sfr_rdata, .o_sfr_wr, .o_sfr_rdata, .o_fosc_clk_en, .o_fosc4_clk_en, .o_nvm_access_en,
    .o_fixed_vref_hold, .o_volt_detect_hold, .o_crc_engine_hold, .o_mem_scanner_hold,
    .o_nonvolatile_hold, .o_clock_ref_hold, .o_pin_change_irq_hold, .o_timer_hold,
    .o_zero_cross_hold, .o_comparator_hold, .o_adc_hold, .o_dac_hold, .o_capcomp_hold,
    .o_pulse_mod_hold, .o_waveform_gen_1_hold, .o_sync_serial_hold, .o_async_serial_hold,
    .o_signal_modulator_hold, .o_periph_settling);
  always #50 i_clk = ~i_clk;
  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      end_of_test();
    end
  end
  // read results are compared against the oldest noted expectation
  always @(posedge i_clk) begin
    if (i_resetn && o_wb_ack === 1'h1 && i_wb_we === 1'h0) begin
      mon_exp = expq.pop_front();
      `CHK(o_wb_dat, mon_exp)
    end
  end
  task automatic bus(input logic we, input int k, input logic [7:0] d, input logic [3:0] sel);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= we;
    i_wb_adr <= {pmb_pkg::IDX_CTRL_0 + 14'(k), 2'h0};
    i_wb_dat <= {24'h0, d};
    i_wb_sel <= sel;
    do begin
      @(posedge i_clk);
    end while (o_wb_ack !== 1'h1);
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic wr(input int k, input logic [7:0] d);
    bus(1'h1, k, d, 4'h1);
    if (k < 6) regs[k*8+:8] = d & pmb_pkg::IMPL_MASK[k*8+:8];
  endtask
  task automatic rd(input int k, input logic [7:0] e);
    expq.push_back({24'h0, e});
    bus(1'h0, k, 8'h00, 4'hf);
  endtask
  task automatic check_all();
    repeat (14) @(posedge i_clk);
    for (int k = 0; k < 6; k++) rd(k, regs[k*8+:8]);
    got_h = {o_fosc_clk_en, o_fixed_vref_hold, o_volt_detect_hold, o_crc_engine_hold,
      o_mem_scanner_hold, o_nonvolatile_hold, o_clock_ref_hold, o_pin_change_irq_hold,
      o_timer_hold, o_dac_hold, o_adc_hold, o_comparator_hold, o_zero_cross_hold,
      o_pulse_mod_hold, o_capcomp_hold, o_async_serial_hold, o_sync_serial_hold,
      o_waveform_gen_1_hold, o_signal_modulator_hold};
    exp_h = {~regs[7], regs[6:0], regs[14:8], regs[22:21], regs[18:16], regs[27:24],
      regs[39:36], regs[32], regs[40]};
    `CHK(got_h[29:15], exp_h[29:15])
    `CHK(got_h[14:0], exp_h[14:0])
    for (int s = 0; s < 48; s++) begin
      exp_b = (pmb_pkg::IMPL_MASK[s] & ~regs[s]) ? i_sfr_rdata[s*8+:8] : 8'h00;
      `CHK(o_sfr_wr[s], i_sfr_wr[s] & pmb_pkg::IMPL_MASK[s] & ~regs[s])
      `CHK(o_sfr_rdata[s*8+:8], exp_b)
    end
  endtask
  initial begin
    void'($urandom(99124));
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'h1;
    @(posedge i_clk);
    for (int k = 0; k < 7; k++) rd(k, (k == 6) ? 8'h02 : 8'h00);
    wr(15, 8'hff);
    rd(15, 8'h00);
    for (int r = 0; r < 4; r++) begin
      for (int s = 0; s < 12; s++) rnd[s*32+:32] = $urandom;
      i_sfr_rdata <= rnd;
      i_sfr_wr <= 48'({$urandom, $urandom});
      for (int k = 0; k < 6; k++) wr(k, 8'($urandom));
      bus(1'h1, r % 6, 8'hff, 4'h0);
      check_all();
    end
    wr(0, 8'h04);
    @(posedge i_clk);
    `CHK(o_nvm_access_en, 1'h0)
    wr(0, 8'h00);
    repeat (2) @(posedge i_clk);
    `CHK(o_nvm_access_en, 1'h0)
    repeat (14) @(posedge i_clk);
    `CHK(o_nvm_access_en, 1'h1)
    wr(6, 8'hff);
    rd(6, 8'h02);
    i_scanner_cfg_enable <= 1'h0;
    i_zero_cross_cfg <= 1'h1;
    wr(2, 8'h01);
    repeat (6) @(posedge i_clk);
    `CHK(o_mem_scanner_hold, 1'h1)
    `CHK(o_zero_cross_hold, 1'h0)
    i_scanner_cfg_enable <= 1'h1;
    i_zero_cross_cfg <= 1'h0;
    wr(1, 8'h01);
    wr(1, 8'h00);
    check_all();
    i_resetn <= 1'h0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'h1;
    regs = '0;
    @(posedge i_clk);
    check_all();
    end_of_test();
  end
endmodule
`default_nettype wire
